// ===== dtc_top.v
// dtc_top: channel transfer sequencing with apb register access.
// assumes one 200 MHz clock, inputs synchronous to it, slaves hold dma_req until acked.
// Functional notes
// - configuration writes are taken only while cpu_hold_ack is low
// - with cpu_hold_ack high only set-up channels transfer, no new configuration
// - transfers repeat while burst stays high and count not expired
// - burst low at start gives one io and one memory cycle
// - slave ends demand transfer by dropping burst, latest in last io cycle
// - controller ends at terminal count, then masks the channel; a lost cpu_hold_ack also ends the run, unmasked
// - verify mode steps address and count but issues only memory reads
// - auto-initialize reloads base address at end and keeps channel unmasked
// - each channel selects address increment or decrement
// - carry across 64 Kbyte segments is silent
// - address wraps to zero at 16M or 4G limit, transfer continues
// - count decrements to FFFF at terminal count; FFFF load runs full range
// - clear-byte-pointer command points at the least significant byte
// - master clear masks all channels and clears every terminal-count status bit; request bits stay live
// - clear-mask command enables all channels
// - write-all-mask command disables all channels
// - enhanced mode gives 32-bit addresses, programmed in four byte accesses
// - outside enhanced mode address bits 24 to 31 stay zero
// - an unwritten top address byte keeps its old value
`timescale 1ns/1ps
`include "dtc_map.vh"
module dtc_top #(
  parameter NCH = 8
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire cpu_hold_ack,
  input wire [NCH-1:0] dma_req,
  input wire burst,
  output reg [NCH-1:0] dma_ack,
  output reg [31:0] mem_addr,
  output reg mem_rd,
  output reg mem_wr,
  output reg io_rd,
  output reg io_wr,
  output reg count_expired,
  output reg transfer_end,
  output reg busy
);
  localparam S_IDLE = 2'h0;
  localparam S_FIRST = 2'h1;
  localparam S_SECOND = 2'h2;
  localparam S_STEP = 2'h3;

  reg [31:0] base_addr [0:NCH-1];
  reg [31:0] cur_addr [0:NCH-1];
  reg [15:0] base_cnt [0:NCH-1];
  reg [15:0] cur_cnt [0:NCH-1];
  reg [3:0] mode [0:NCH-1];
  reg [NCH-1:0] mask;
  reg [NCH-1:0] tc_flag;
  reg enh;
  reg [2:0] chsel;
  reg [1:0] bptr;
  reg [1:0] state;
  reg [2:0] ch;
  reg burst_run;
  reg burst_io;
  integer i;
  genvar gi;

  // a channel competes only while unmasked
  wire [NCH-1:0] eligible;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_elig
      assign eligible[gi] = dma_req[gi] & ~mask[gi];
    end
  endgenerate

  // lowest numbered unmasked requester wins; no rotation, fairness is not offered
  reg [2:0] pick;
  reg pick_ok;
  always @* begin
    pick = 3'h0;
    pick_ok = 1'b0;
    for (i = NCH - 1; i >= 0; i = i - 1) begin
      if (eligible[i]) begin
        pick = i[2:0];
        pick_ok = 1'b1;
      end
    end
  end

  wire [1:0] ch_type = mode[ch][`DTC_MODE_TYPE_LSB +: 2];
  wire ch_auto = mode[ch][`DTC_MODE_AUTO];
  wire [31:0] step_addr;
  wire [15:0] step_cnt;
  wire step_tc;

  dtc_addr_step u_addr (
    .addr(cur_addr[ch]),
    .dec(mode[ch][`DTC_MODE_DEC]),
    .enh(enh),
    .next_addr(step_addr)
  );

  // one step unit serves all channels; only the running channel is presented to it
  dtc_count_step u_cnt (
    .count(cur_cnt[ch]),
    .next_count(step_cnt),
    .expired(step_tc)
  );

  // first access cycle only, so the wait state never lands a write twice
  wire acc = psel & penable & ~pready;
  wire wr = acc & pwrite;
  wire cfg_ok = ~cpu_hold_ack;
  wire cfg_wr = wr & cfg_ok;
  wire cmd_wr = cfg_wr && paddr == `DTC_OFS_CMD;
  wire clr_ptr = cmd_wr && pwdata[`DTC_CMD_CLR_PTR];
  wire mclr = cmd_wr && pwdata[`DTC_CMD_MCLR];
  wire addr_acc = acc && paddr == `DTC_OFS_ADDR && (cfg_ok || !pwrite);
  wire cnt_acc = acc && paddr == `DTC_OFS_COUNT && (cfg_ok || !pwrite);

  function mapped;
    input [7:0] a;
    begin
      mapped = a == `DTC_OFS_CTRL || a == `DTC_OFS_CMD || a == `DTC_OFS_CHSEL ||
               a == `DTC_OFS_ADDR || a == `DTC_OFS_COUNT || a == `DTC_OFS_MODE ||
               a == `DTC_OFS_MASK || a == `DTC_OFS_STATUS || a == `DTC_OFS_CURADR;
    end
  endfunction

  // address as driven: the top byte is stored but not driven outside enhanced mode
  function [31:0] bus_addr;
    input [31:0] a;
    input e;
    begin
      if (e) begin
        bus_addr = a;
      end else begin
        bus_addr = {8'h00, a[`DTC_LEGACY_TOP-1:0]};
      end
    end
  endfunction

  // apb answer: one wait state, pready high in the second access cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      pslverr <= acc & ~mapped(paddr);
      if (acc && !pwrite) begin
        case (paddr)
          `DTC_OFS_CTRL: prdata <= {31'h0, enh};
          `DTC_OFS_CHSEL: prdata <= {29'h0, chsel};
          `DTC_OFS_ADDR: prdata <= {24'h0, cur_addr[chsel][{bptr, 3'b000} +: 8]};
          `DTC_OFS_COUNT: prdata <= {24'h0, cur_cnt[chsel][{bptr[0], 3'b000} +: 8]};
          `DTC_OFS_MODE: prdata <= {28'h0, mode[chsel]};
          `DTC_OFS_MASK: prdata <= {{(32-NCH){1'b0}}, mask};
          `DTC_OFS_STATUS: begin
            // flags and live requests keep fixed byte lanes
            prdata <= 32'h0000_0000;
            prdata[NCH-1:0] <= tc_flag;
            prdata[`DTC_STATUS_REQ_LSB +: NCH] <= dma_req;
          end
          `DTC_OFS_CURADR: prdata <= cur_addr[chsel];
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // byte pointer shared by the address and count ports
  // reads advance it as well, so a read-back starts with a clear-pointer command
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bptr <= 2'h0;
    end else if (mclr || clr_ptr) begin
      bptr <= 2'h0;
    end else if (addr_acc) begin
      bptr <= (bptr == `DTC_ADDR_LAST) ? 2'h0 : bptr + 2'h1;
    end else if (cnt_acc) begin
      bptr <= (bptr >= `DTC_COUNT_LAST) ? 2'h0 : bptr + 2'h1;
    end
  end

  // plain control registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enh <= 1'b0;
      chsel <= 3'h0;
    end else if (cfg_wr) begin
      if (paddr == `DTC_OFS_CTRL) begin
        enh <= pwdata[`DTC_CTRL_ENH];
      end
      if (paddr == `DTC_OFS_CHSEL) begin
        chsel <= pwdata[2:0];
      end
    end
  end

  // channel state, mask, status and the transfer sequencer share one process
  // because both software and the sequencer update the same channel words
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < NCH; i = i + 1) begin
        base_addr[i] <= `DTC_RST_ADDR;
        cur_addr[i] <= `DTC_RST_ADDR;
        base_cnt[i] <= `DTC_RST_COUNT;
        cur_cnt[i] <= `DTC_RST_COUNT;
        mode[i] <= `DTC_RST_MODE;
      end
      mask <= {NCH{1'b1}};
      tc_flag <= {NCH{1'b0}};
      state <= S_IDLE;
      ch <= 3'h0;
      burst_run <= 1'b0;
      burst_io <= 1'b0;
      dma_ack <= {NCH{1'b0}};
      mem_addr <= 32'h0000_0000;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      io_rd <= 1'b0;
      io_wr <= 1'b0;
      count_expired <= 1'b0;
      transfer_end <= 1'b0;
      busy <= 1'b0;
    end else begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      io_rd <= 1'b0;
      io_wr <= 1'b0;
      count_expired <= 1'b0;
      transfer_end <= 1'b0;

      if (cfg_wr) begin
        case (paddr)
          `DTC_OFS_ADDR: begin
            // bytes not written keep their old value
            base_addr[chsel][{bptr, 3'b000} +: 8] <= pwdata[7:0];
            cur_addr[chsel][{bptr, 3'b000} +: 8] <= pwdata[7:0];
          end
          `DTC_OFS_COUNT: begin
            base_cnt[chsel][{bptr[0], 3'b000} +: 8] <= pwdata[7:0];
            cur_cnt[chsel][{bptr[0], 3'b000} +: 8] <= pwdata[7:0];
          end
          `DTC_OFS_MODE: mode[chsel] <= pwdata[3:0];
          `DTC_OFS_MASK: mask <= pwdata[NCH-1:0];
          `DTC_OFS_CMD: begin
            if (pwdata[`DTC_CMD_CLR_MASK]) begin
              mask <= {NCH{1'b0}};
            end
            // set-all comes last so it wins when both bits are written
            if (pwdata[`DTC_CMD_SET_MASK]) begin
              mask <= {NCH{1'b1}};
            end
          end
          default: ;
        endcase
      end

      if (mclr) begin
        mask <= {NCH{1'b1}};
        tc_flag <= {NCH{1'b0}};
        state <= S_IDLE;
        dma_ack <= {NCH{1'b0}};
        busy <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            // only a hold-acknowledged bus runs already programmed channels
            if (cpu_hold_ack && pick_ok) begin
              ch <= pick;
              burst_run <= burst;
              dma_ack <= {{(NCH-1){1'b0}}, 1'b1} << pick;
              mem_addr <= bus_addr(cur_addr[pick], enh);
              busy <= 1'b1;
              state <= S_FIRST;
            end
          end
          S_FIRST: begin
            if (ch_type == `DTC_TYPE_TOMEM) begin
              io_rd <= 1'b1;
              burst_io <= burst;
              state <= S_SECOND;
            end else if (ch_type == `DTC_TYPE_FROMMEM) begin
              mem_rd <= 1'b1;
              state <= S_SECOND;
            end else begin
              mem_rd <= 1'b1;
              burst_io <= burst;
              state <= S_STEP;
            end
          end
          S_SECOND: begin
            if (ch_type == `DTC_TYPE_TOMEM) begin
              mem_wr <= 1'b1;
            end else begin
              io_wr <= 1'b1;
              burst_io <= burst;
            end
            state <= S_STEP;
          end
          S_STEP: begin
            // a started pair finishes unless a master clear cuts it; a lost hold-acknowledge ends the run here
            cur_addr[ch] <= step_addr;
            cur_cnt[ch] <= step_cnt;
            mem_addr <= step_addr;
            if (step_tc) begin
              count_expired <= 1'b1;
              transfer_end <= 1'b1;
              // sticky until master clear
              tc_flag[ch] <= 1'b1;
              dma_ack <= {NCH{1'b0}};
              busy <= 1'b0;
              state <= S_IDLE;
              if (ch_auto) begin
                cur_addr[ch] <= base_addr[ch];
                cur_cnt[ch] <= base_cnt[ch];
              end else begin
                mask[ch] <= 1'b1;
              end
            end else if (burst_run && burst_io && burst && cpu_hold_ack && !mask[ch]) begin
              state <= S_FIRST;
            end else begin
              // slave dropped burst: one pair done, stop without masking
              dma_ack <= {NCH{1'b0}};
              busy <= 1'b0;
              state <= S_IDLE;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end
endmodule

// ===== dtc_map.vh
// dtc_map.vh: register offsets, field positions and reset values of the dma transfer control.
// assumes byte addresses on an 8-bit apb paddr, one 32-bit word per register.
`ifndef DTC_MAP_VH
`define DTC_MAP_VH
`define DTC_OFS_CTRL 8'h00
`define DTC_OFS_CMD 8'h04
`define DTC_OFS_CHSEL 8'h08
`define DTC_OFS_ADDR 8'h0C
`define DTC_OFS_COUNT 8'h10
`define DTC_OFS_MODE 8'h14
`define DTC_OFS_MASK 8'h18
`define DTC_OFS_STATUS 8'h1C
`define DTC_OFS_CURADR 8'h20
`define DTC_CTRL_ENH 0
`define DTC_CMD_CLR_PTR 0
`define DTC_CMD_MCLR 1
`define DTC_CMD_CLR_MASK 2
`define DTC_CMD_SET_MASK 3
`define DTC_MODE_TYPE_LSB 0
`define DTC_MODE_AUTO 2
`define DTC_MODE_DEC 3
`define DTC_TYPE_VERIFY 2'h0
`define DTC_TYPE_TOMEM 2'h1
`define DTC_TYPE_FROMMEM 2'h2
`define DTC_STATUS_REQ_LSB 8
`define DTC_ADDR_LAST 2'h3
`define DTC_COUNT_LAST 2'h1
`define DTC_RST_ADDR 32'h0000_0000
`define DTC_RST_COUNT 16'hFFFF
`define DTC_RST_MODE 4'h0
`define DTC_LEGACY_TOP 24
`endif

// ===== dtc_addr_step.v
// dtc_addr_step: next memory address after one transfer.
// assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps
module dtc_addr_step (
  input wire [31:0] addr,
  input wire dec,
  input wire enh,
  output reg [31:0] next_addr
);
  reg [31:0] stepped;
  always @* begin
    stepped = dec ? addr - 32'h0000_0001 : addr + 32'h0000_0001;
    // 24-bit wrap outside enhanced mode; carries between bytes are silent
    if (enh) begin
      next_addr = stepped;
    end else begin
      next_addr = {8'h00, stepped[`DTC_LEGACY_TOP-1:0]};
    end
  end
endmodule

// ===== dtc_count_step.v
// dtc_count_step: transfer count decrement and terminal-count detect.
// assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps
module dtc_count_step (
  input wire [15:0] count,
  output wire [15:0] next_count,
  output wire expired
);
  // zero before the step means this transfer is the last; it lands on FFFF
  assign expired = (count == 16'h0000);
  assign next_count = count - 16'h0001;
endmodule

// ===== dtc_checker.sv
// dtc_checker: port assertions on dtc_top.
// assumes a bind to dtc_top; sees its ports only.
`timescale 1ns/1ps
module dtc_checker #(
  parameter NCH = 8
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire cpu_hold_ack,
  input wire [NCH-1:0] dma_ack,
  input wire mem_rd,
  input wire mem_wr,
  input wire io_rd,
  input wire io_wr,
  input wire count_expired,
  input wire transfer_end,
  input wire busy
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire stb = mem_rd | mem_wr | io_rd | io_wr;
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  pready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  start_held_a: assert property ($rose(busy) |-> $past(cpu_hold_ack))
    else $error("run started without hold");
  strobe_owned_a: assert property (stb |-> busy && $onehot(dma_ack))
    else $error("strobe outside a run");
  one_strobe_a: assert property ($onehot0({mem_rd, mem_wr, io_rd, io_wr}))
    else $error("strobes overlap");
  io_then_mem_a: assert property (io_rd |=> mem_wr)
    else $error("io read not followed by memory write");
  mem_then_io_a: assert property (io_wr |-> $past(mem_rd))
    else $error("io write without memory read");
  end_at_count_a: assert property (transfer_end |-> count_expired)
    else $error("end without terminal count");
  expire_pulse_a: assert property (count_expired |=> !count_expired)
    else $error("terminal count held");
  cover property (transfer_end);
  cover property (io_wr);
  cover property (pslverr);
endmodule
bind dtc_top dtc_checker #(.NCH(NCH)) i_dtc_checker (.clk, .rst_n, .psel, .penable, .pready,
  .pslverr, .cpu_hold_ack, .dma_ack, .mem_rd, .mem_wr, .io_rd, .io_wr, .count_expired,
  .transfer_end, .busy);

// ===== dtc_slave_model.sv
// dtc_slave_model: channel slave asking for a set number of transfer pairs.
// assumes dtc_top strobes; burst drops in the last io cycle of the run.
`timescale 1ns/1ps
module dtc_slave_model #(
  parameter NCH = 8
) (
  input wire clk,
  input wire rst_n,
  input wire arm,
  input wire [2:0] ch,
  input wire [7:0] pairs,
  input wire vfy,
  input wire io_rd,
  input wire io_wr,
  input wire mem_rd,
  output logic [NCH-1:0] dma_req,
  output logic burst
);
  logic [7:0] left;
  // verify runs have no io cycle, so the memory read stands in for it
  wire io_now = io_rd | io_wr | (mem_rd & vfy);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      left <= 8'h0;
    else if (arm)
      left <= pairs;
    else if (io_now && left != 8'h0)
      left <= left - 8'h1;
  end
  // a lone pair never raises burst
  assign burst = pairs > 8'h1 && (left > 8'h1 || (left == 8'h1 && !io_now));
  assign dma_req = left != 8'h0 ? NCH'(1) << ch : '0;
endmodule

// ===== testbench.sv
// testbench: apb host and hold driver for dtc_top, slave model on the far side.
// assumes byte-wide address and count ports and an address step of one.
`timescale 1ns/1ps
`include "dtc_map.vh"
module testbench;
  logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic cpu_hold_ack = 1'h0, arm = 1'h0, vfy = 1'h0, enh = 1'h0, e;
  logic [7:0] paddr = 8'h0, pairs = 8'h0, np = 8'h0, dma_req, dma_ack;
  logic [2:0] ch = 3'h0;
  logic [31:0] pwdata = 32'h0, prdata, mem_addr, r;
  logic pready, pslverr, burst, mem_rd, mem_wr, io_rd, io_wr, count_expired, transfer_end, busy;
  int num_errors = 0, total_checks = 0, n[5] = '{5{0}};
  wire [4:0] ev = {count_expired, io_rd, io_wr, mem_rd, mem_wr};
  always #2.5 clk = ~clk;
  always @(posedge clk)
    for (int i = 0; i < 5; i++)
      n[i] <= n[i] + ev[i];
  dtc_top #(.NCH(8)) i_dtc_top (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cpu_hold_ack, .dma_req, .burst, .dma_ack, .mem_addr, .mem_rd,
    .mem_wr, .io_rd, .io_wr, .count_expired, .transfer_end, .busy);
  dtc_slave_model #(.NCH(8)) i_dtc_slave_model (.clk, .rst_n, .arm, .ch, .pairs, .vfy,
    .io_rd, .io_wr, .mem_rd, .dma_req, .burst);
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (s !== v && k < 3000);
    if (k >= 3000) begin
      num_errors++;
      $display("mismatch %0t wait timed out", $time);
      give_verdict;
    end
  endtask
  // the idle cycle at the end keeps back-to-back calls from driving psel twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    wait_for(pready, 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] d, input int nb);
    apb(1'h1, `DTC_OFS_CMD, 32'h1);
    for (int i = 0; i < nb; i++)
      apb(1'h1, a, {24'h0, d[8*i +: 8]});
  endtask
  task automatic run(input logic [2:0] c, input logic [3:0] md, input logic [31:0] ad,
      input logic [15:0] cnt, input logic [19:0] ex, input logic [31:0] fin, input logic mk);
    int b[5];
    logic [19:0] g;
    b = n;
    apb(1'h1, `DTC_OFS_CHSEL, {29'h0, c});
    apb(1'h1, `DTC_OFS_MODE, {28'h0, md});
    put(`DTC_OFS_ADDR, ad, 4);
    put(`DTC_OFS_COUNT, {16'h0, cnt}, 2);
    apb(1'h1, `DTC_OFS_MASK, ~(32'h1 << c));
    ch <= c;
    pairs <= (np != 8'h0) ? np : cnt[7:0] + 8'h1;
    vfy <= md[1:0] == `DTC_TYPE_VERIFY;
    arm <= 1'h1;
    cpu_hold_ack <= 1'h1;
    @(posedge clk);
    arm <= 1'h0;
    wait_for(busy, 1'h1);
    chk(mem_addr, enh ? ad : {8'h0, ad[23:0]}, "start address");
    wait_for(busy, 1'h0);
    cpu_hold_ack <= 1'h0;
    @(posedge clk);
    for (int i = 0; i < 5; i++)
      g[4*i +: 4] = 4'(n[i] - b[i]);
    chk({12'h0, g}, {12'h0, ex}, "strobe counts");
    apb(1'h0, `DTC_OFS_CURADR, 32'h0);
    chk(r, fin, "current address");
    apb(1'h0, `DTC_OFS_MASK, 32'h0);
    chk({31'h0, r[c]}, {31'h0, mk}, "mask bit");
    $display("run on channel %0d done", c);
  endtask
  task automatic t_regs;
    apb(1'h0, `DTC_OFS_MASK, 32'h0);
    chk(r, 32'hFF, "reset mask");
    apb(1'h0, 8'h40, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped error");
    apb(1'h1, `DTC_OFS_CMD, 32'h4);
    apb(1'h0, `DTC_OFS_MASK, 32'h0);
    chk(r, 32'h0, "clear mask");
    apb(1'h1, `DTC_OFS_CMD, 32'h8);
    cpu_hold_ack <= 1'h1;
    apb(1'h1, `DTC_OFS_MASK, 32'h0);
    cpu_hold_ack <= 1'h0;
    apb(1'h0, `DTC_OFS_MASK, 32'h0);
    chk(r, 32'hFF, "mask after held write");
    $display("register test done");
  endtask
  task automatic t_ptr;
    apb(1'h1, `DTC_OFS_CTRL, 32'h1);
    enh = 1'h1;
    put(`DTC_OFS_ADDR, 32'h12345678, 4);
    put(`DTC_OFS_ADDR, 32'h00AABBCC, 3);
    apb(1'h1, `DTC_OFS_CMD, 32'h1);
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, `DTC_OFS_ADDR, 32'h0);
      chk({24'h0, r[7:0]}, 32'h12AABBCC >> (8*i) & 32'hFF, "address byte");
    end
    $display("pointer test done");
  endtask
  task automatic t_runs;
    run(3'h2, 4'h1, 32'hFFFFFFFF, 16'h0, 20'h11001, 32'h0, 1'h1);
    apb(1'h1, `DTC_OFS_CTRL, 32'h0);
    enh = 1'h0;
    run(3'h0, 4'h1, 32'h100, 16'h0, 20'h11001, 32'h101, 1'h1);
    run(3'h3, 4'h2, 32'hFFFF, 16'h2, 20'h10330, 32'h10002, 1'h1);
    run(3'h5, 4'hC, 32'h10, 16'h1, 20'h10020, 32'h10, 1'h0);
    run(3'h1, 4'h1, 32'hAAFFFFFF, 16'h0, 20'h11001, 32'h0, 1'h1);
  endtask
  // slave stops with count left: no terminal count, channel stays unmasked
  task automatic t_stop;
    np = 8'h2;
    run(3'h4, 4'h1, 32'h200, 16'h5, 20'h02002, 32'h202, 1'h0);
    np = 8'h1;
    run(3'h6, 4'h2, 32'h300, 16'h5, 20'h00110, 32'h301, 1'h0);
    np = 8'h0;
    $display("slave stop test done");
  endtask
  task automatic t_clear;
    apb(1'h1, `DTC_OFS_CMD, 32'h1);
    for (int i = 0; i < 2; i++) begin
      apb(1'h0, `DTC_OFS_COUNT, 32'h0);
      chk({24'h0, r[7:0]}, 32'hFF, "count byte");
    end
    apb(1'h1, `DTC_OFS_CMD, 32'h2);
    apb(1'h0, `DTC_OFS_MASK, 32'h0);
    chk(r, 32'hFF, "mask");
    apb(1'h0, `DTC_OFS_STATUS, 32'h0);
    chk({24'h0, r[7:0]}, 32'h0, "status");
    $display("clear test done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_regs;
    t_ptr;
    t_stop;
    t_runs;
    t_clear;
    give_verdict;
  end
endmodule
